//--- mshp_host_model.sv
// Purpose: host end of the serial link, sends and captures frames
// Assumes: same clock as the port, frames given lsb first
// Notes:   pin high is logical zero on both lines
`timescale 1ns/1ps
module mshp_host_model #(
    parameter int BIT_CYC = 4160
) (
    // clock
    input  wire logic clk_i,
    // serial pins
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b0;

    // no handshake wait, the port offers none
    task automatic send(input logic [10:0] f, input int n);
        @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= ~f[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask : send

    // unused upper bits read as ones; no start leaves all unknown
    task automatic recv(output logic [10:0] f, input int n);
        int w;
        f = 'x;
        w = 0;
        while (line_i !== 1'b1 && w < 4 * BIT_CYC) begin
            @(posedge clk_i);
            w++;
        end
        if (line_i !== 1'b1) return;
        f = 11'h7ff;
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = ~line_i;
            if (i < n - 1) repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask : recv
endmodule : mshp_host_model

//--- mshp_monitor.sv
// Purpose: concurrent checks on the serial host port pins
// Assumes: one clock domain, bound onto mshp_top
// Notes:   bit time is the divider times sixteen, exact
`timescale 1ns/1ps
`include "mshp_regs.svh"
module mshp_monitor #(
    parameter int unsigned HOLD_CYC = 50
) (
    // clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   rst_i,
    // register bus
    input wire logic [`MSHP_ADDR_W-1:0] avs_address_i,
    input wire logic                   avs_write_i,
    input wire logic [3:0]             avs_byteenable_i,
    input wire logic [31:0]            avs_writedata_i,
    input wire logic                   avs_waitrequest_o,
    input wire logic                   irq_o,
    // pins
    input wire logic                   host_rxd_o,
    input wire logic                   status_n_o,
    input wire logic                   cts_o,
    input wire logic                   cts_oe_n_o,
    input wire logic                   panel_btn_i,
    input wire logic [`MSHP_CFG_W-1:0] nv_cfg_i,
    input wire logic [`MSHP_CFG_W-1:0] cfg_o
);
    localparam int BIT_CYC = `MSHP_OVS_DIV * `MSHP_OVS;
    logic        prev_q;
    logic        seen_q;
    logic        drop_q;
    logic [31:0] run_q;
    logic [31:0] held_q;
    wire acc_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire ctrl_wr = acc_done && avs_address_i == `MSHP_CTRL_ADDR;
    wire txd_wr = acc_done && avs_address_i == `MSHP_TXD_ADDR;
    wire mask_wr = acc_done && avs_address_i == `MSHP_MASK_ADDR;
    wire dflt_ok = ((cfg_o ^ `MSHP_CFG_DEFAULT) & 13'h0fff) == 13'h0;

    // length of the current run of one pin level
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            seen_q <= 1'b0;
            run_q  <= 32'h0;
        end else begin
            prev_q <= host_rxd_o;
            run_q  <= (host_rxd_o != prev_q) ? 32'h1 : run_q + 32'h1;
            if (host_rxd_o) seen_q <= 1'b1;
        end
    end

    // a release before the hold time abandons the restore
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drop_q <= 1'b0;
            held_q <= 32'h0;
        end else begin
            if (!panel_btn_i) drop_q <= 1'b1;
            if (panel_btn_i && !drop_q) held_q <= held_q + 32'h1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    AST_CTS_UNDRIVEN: assert property (cts_oe_n_o && !cts_o)
        else $error("handshake pin driven");
    AST_SRQ_LEVEL: assert property (ctrl_wr |-> ##2
        status_n_o == !$past(avs_writedata_i[3], 2))
        else $error("service request level wrong");
    AST_BIT_TIME: assert property ($fell(host_rxd_o) |->
        (run_q % BIT_CYC) == 0)
        else $error("serial bit time wrong");
    AST_TX_START: assert property ((txd_wr && !host_rxd_o &&
        (!seen_q || run_q > 10 * BIT_CYC)) |-> ##[1:300] host_rxd_o)
        else $error("start bit not driven high");
    AST_IDLE_PIN: assert property ($fell(rst_i) |->
        !host_rxd_o ##1 !host_rxd_o)
        else $error("line not idle after reset");
    AST_CFG_NV: assert property ($fell(rst_i) |->
        ##[1:3] cfg_o == nv_cfg_i)
        else $error("stored settings not restored");
    AST_RST_CMD: assert property ((ctrl_wr && avs_writedata_i[4]) |->
        ##[2:4] dflt_ok)
        else $error("restore command gave no defaults");
    AST_BTN_HOLD: assert property ((held_q == HOLD_CYC + 8 && !drop_q)
        |-> dflt_ok)
        else $error("button hold gave no defaults");
    AST_IRQ_MASKED: assert property ((mask_wr && avs_writedata_i[5:0] == 6'h0)
        |-> ##3 !irq_o)
        else $error("interrupt high with mask clear");

    COV_TX: cover property (txd_wr);
    COV_IRQ: cover property ($rose(irq_o));
    COV_CMD: cover property (ctrl_wr && avs_writedata_i[4]);
endmodule : mshp_monitor

bind mshp_top mshp_monitor #(.HOLD_CYC(HOLD_CYC)) u_mon (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .host_rxd_o(host_rxd_o), .status_n_o(status_n_o),
    .cts_o(cts_o), .cts_oe_n_o(cts_oe_n_o), .panel_btn_i(panel_btn_i),
    .nv_cfg_i(nv_cfg_i), .cfg_o(cfg_o)
);

//--- mshp_pkg.sv
// Purpose: types shared by the serial host port
// Assumes: nothing
// Notes:   state enums and parity modes
package mshp_pkg;
    typedef enum logic [1:0] {
        MSHP_IDLE, MSHP_START, MSHP_DATA, MSHP_STOP
    } mshp_rx_state_t;

    typedef enum logic [2:0] {
        MSHP_T_IDLE, MSHP_T_START, MSHP_T_DATA, MSHP_T_PAR, MSHP_T_STOP
    } mshp_tx_state_t;

    typedef enum logic [2:0] {
        MSHP_PAR_NONE, MSHP_PAR_ODD, MSHP_PAR_EVEN,
        MSHP_PAR_MARK, MSHP_PAR_SPACE
    } mshp_par_t;
endpackage : mshp_pkg

//--- mshp_regs.svh
// Purpose: register map, field positions and timing constants
// Assumes: 40 MHz core clock, byte addressed avalon slave
// Notes:   definitions only
`ifndef MSHP_REGS_SVH
`define MSHP_REGS_SVH

`define MSHP_ADDR_W        8
`define MSHP_CTRL_ADDR     8'h00
`define MSHP_STAT_ADDR     8'h04
`define MSHP_MASK_ADDR     8'h08
`define MSHP_TXD_ADDR      8'h0c
`define MSHP_RXD_ADDR      8'h10
`define MSHP_CFG_ADDR      8'h14
`define MSHP_LINK_ADDR     8'h18

// ctrl fields
`define MSHP_CTRL_PAR_LO   0
`define MSHP_CTRL_PAR_HI   2
`define MSHP_CTRL_SRQ      3
`define MSHP_CTRL_DEFLOAD  4
`define MSHP_PAR_RESET     3'h0

// status / mask bits
`define MSHP_ST_W          6
`define MSHP_ST_RXRDY      0
`define MSHP_ST_TXDONE     1
`define MSHP_ST_OVERRUN    2
`define MSHP_ST_PARERR     3
`define MSHP_ST_FRMERR     4
`define MSHP_ST_DEFLT      5

// rx data valid flag position
`define MSHP_RXD_VALID     8

// configuration word
`define MSHP_CFG_W         13
`define MSHP_CFG_DEFAULT   13'h0316
`define MSHP_CFG_LINE50    12

// serial timing
`define MSHP_CLK_HZ        40000000
`define MSHP_BAUD          9600
`define MSHP_OVS           16
`define MSHP_OVS_DIV       (`MSHP_CLK_HZ / (`MSHP_BAUD * `MSHP_OVS))
`define MSHP_HALF_BIT      4'h7
`define MSHP_LAST_TICK     4'hf
`define MSHP_LAST_DBIT     3'h7

// power-up button hold
`define MSHP_HOLD_MS       2000
`define MSHP_HOLD_CYC      ((`MSHP_CLK_HZ / 1000) * `MSHP_HOLD_MS)

`endif

//--- mshp_top.sv
// What this block does
// - default configuration word loaded on restore, line frequency bit kept
// - button held two seconds at power-up restores
// - reset command restores the same defaults
// - service request output low when asserted
// - inverted line levels, host in, device out
// - power-on 9600 baud, 8N1 framing
// - baud rate fixed, nothing changes it
// - no flow control, rts ignored, cts undriven
// - parity mode rewritten by every ctrl register write with byte 0 enabled, service request and reset commands included
// - 10 MHz reference lines left unconnected
// - stored settings restored unless defaults requested
//
// Purpose: serial host port with avalon-mm register access
// Assumes: firmware parses commands and drives ctrl register
// Notes:   line pins carry logical bits inverted
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mshp_regs.svh"

module mshp_top
    import mshp_pkg::*;
#(
    parameter int unsigned HOLD_CYC = `MSHP_HOLD_CYC
) (
    // clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    // avalon-mm slave
    input  wire logic [`MSHP_ADDR_W-1:0] avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [3:0]              avs_byteenable_i,
    input  wire logic [31:0]             avs_writedata_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    output logic                         irq_o,
    // serial link pins
    input  wire logic                    host_txd_i,
    output logic                         host_rxd_o,
    output logic                         status_n_o,
    input  wire logic                    rts_i,
    output logic                         cts_o,
    output logic                         cts_oe_n_o,
    // panel and stored settings
    input  wire logic                    panel_btn_i,
    input  wire logic [`MSHP_CFG_W-1:0]  nv_cfg_i,
    output logic      [`MSHP_CFG_W-1:0]  cfg_o
);
    // reference clock pins do not exist on this block
    localparam int unsigned OVS_DIV = `MSHP_OVS_DIV;

    // ---------------- bus front end ----------------
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] wmask;
    logic [31:0] wbits;

    assign acc    = (avs_read_i | avs_write_i) & ~wait_q;
    assign wr_acc = avs_write_i & ~wait_q;
    assign rd_acc = avs_read_i & ~wait_q;
    assign wmask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wbits  = avs_writedata_i & wmask;

    // one wait cycle: request seen, then answered on the next edge
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else if (acc) begin
            wait_q <= 1'b1;
        end else if (avs_read_i | avs_write_i) begin
            wait_q <= 1'b0;
        end
    end

    // ---------------- register state ----------------
    logic [2:0]              par_q;
    logic                    srq_q;
    logic [`MSHP_ST_W-1:0]   stat_q;
    logic [`MSHP_ST_W-1:0]   mask_q;
    logic [`MSHP_CFG_W-1:0]  cfg_q;
    logic [7:0]              rxd_q;
    logic                    rxv_q;
    logic                    boot_q;
    logic                    hold_act_q;
    logic [31:0]             hold_cnt_q;
    logic                    tx_busy;
    logic [`MSHP_ST_W-1:0]   ev;
    logic                    deflt_cmd;
    logic                    hold_done;

    assign deflt_cmd = wr_acc && avs_address_i == `MSHP_CTRL_ADDR
                       && wbits[`MSHP_CTRL_DEFLOAD];

    // parity only moves on the command write; baud has no register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            par_q <= `MSHP_PAR_RESET;
            srq_q <= 1'b0;
        end else if (wr_acc && avs_address_i == `MSHP_CTRL_ADDR) begin
            if (avs_byteenable_i[0]) begin
                par_q <= avs_writedata_i[`MSHP_CTRL_PAR_HI:`MSHP_CTRL_PAR_LO];
                srq_q <= avs_writedata_i[`MSHP_CTRL_SRQ];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= '0;
        end else if (wr_acc && avs_address_i == `MSHP_MASK_ADDR) begin
            mask_q <= (mask_q & ~wmask[`MSHP_ST_W-1:0])
                      | wbits[`MSHP_ST_W-1:0];
        end
    end

    // button synchroniser and power-up hold timer
    logic btn_s1_q;
    logic btn_s2_q;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // starts held, else the sync fill closes the hold window
            btn_s1_q <= 1'b1;
            btn_s2_q <= 1'b1;
        end else begin
            btn_s1_q <= panel_btn_i;
            btn_s2_q <= btn_s1_q;
        end
    end

    // only a hold that starts at power-up and never lets go counts
    assign hold_done = hold_act_q && btn_s2_q
                       && hold_cnt_q == HOLD_CYC - 1;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_act_q <= 1'b1;
            hold_cnt_q <= '0;
        end else if (hold_act_q) begin
            if (!btn_s2_q && !boot_q) begin
                hold_act_q <= 1'b0;
            end else if (hold_done) begin
                hold_act_q <= 1'b0;
            end else if (!boot_q) begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
            end
        end
    end

    // stored settings caught on the first edge after reset release
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_q <= 1'b1;
            cfg_q  <= `MSHP_CFG_DEFAULT;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            cfg_q  <= nv_cfg_i;
        end else if (hold_done || deflt_cmd) begin
            // line frequency is a stored setting, not a default
            cfg_q <= (`MSHP_CFG_DEFAULT & ~(13'h1 << `MSHP_CFG_LINE50))
                     | (cfg_q & (13'h1 << `MSHP_CFG_LINE50));
        end else if (wr_acc && avs_address_i == `MSHP_CFG_ADDR) begin
            cfg_q <= (cfg_q & ~wmask[`MSHP_CFG_W-1:0])
                     | wbits[`MSHP_CFG_W-1:0];
        end
    end

    // ---------------- oversample tick ----------------
    logic [8:0] div_q;
    logic       tick;
    assign tick = div_q == 9'(OVS_DIV - 1);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 9'h1;
        end
    end

    // parity of a byte for the current mode
    function automatic logic par_bit(input logic [2:0] m,
                                     input logic [7:0] d);
        case (m)
            MSHP_PAR_ODD:   par_bit = ~^d;
            MSHP_PAR_EVEN:  par_bit = ^d;
            MSHP_PAR_MARK:  par_bit = 1'b1;
            default:        par_bit = 1'b0;
        endcase
    endfunction : par_bit

    logic par_on;
    assign par_on = par_q != MSHP_PAR_NONE && par_q <= MSHP_PAR_SPACE;

    // ---------------- receiver ----------------
    logic rx_s1_q;
    logic rx_s2_q;
    logic rx_bit;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
        end else begin
            rx_s1_q <= host_txd_i;
            rx_s2_q <= rx_s1_q;
        end
    end
    assign rx_bit = ~rx_s2_q;

    mshp_rx_state_t rx_st_q;
    logic [3:0]     rx_tk_q;
    logic [3:0]     rx_n_q;
    logic [8:0]     rx_sh_q;
    logic           rx_done;
    logic           rx_perr;
    logic           rx_ferr;
    logic [3:0]     rx_len;
    assign rx_len = par_on ? 4'h9 : 4'h8;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_q <= MSHP_IDLE;
            rx_tk_q <= '0;
            rx_n_q  <= '0;
            rx_sh_q <= '0;
            rx_done <= 1'b0;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_tk_q <= rx_tk_q + 4'h1;
                case (rx_st_q)
                    MSHP_IDLE: begin
                        rx_tk_q <= '0;
                        if (!rx_bit) begin
                            rx_st_q <= MSHP_START;
                        end
                    end
                    MSHP_START: begin
                        if (rx_tk_q == `MSHP_HALF_BIT) begin
                            rx_tk_q <= '0;
                            rx_n_q  <= '0;
                            rx_st_q <= rx_bit ? MSHP_IDLE : MSHP_DATA;
                        end
                    end
                    MSHP_DATA: begin
                        if (rx_tk_q == `MSHP_LAST_TICK) begin
                            // lsb first, parity lands in bit 8
                            rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
                            rx_n_q  <= rx_n_q + 4'h1;
                            if (rx_n_q == rx_len - 4'h1) begin
                                rx_st_q <= MSHP_STOP;
                            end
                        end
                    end
                    MSHP_STOP: begin
                        if (rx_tk_q == `MSHP_LAST_TICK) begin
                            rx_st_q <= MSHP_IDLE;
                            rx_done <= 1'b1;
                            rx_ferr <= !rx_bit;
                            rx_perr <= par_on && (par_on ?
                                rx_sh_q[8] != par_bit(par_q, rx_sh_q[7:0])
                                : 1'b0);
                        end
                    end
                    default: rx_st_q <= MSHP_IDLE;
                endcase
            end
        end
    end

    logic [7:0] rx_byte;
    assign rx_byte = par_on ? rx_sh_q[7:0] : rx_sh_q[8:1];

    logic rxd_rd;
    assign rxd_rd = rd_acc && avs_address_i == `MSHP_RXD_ADDR;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxd_q <= '0;
            rxv_q <= 1'b0;
        end else if (rx_done) begin
            rxd_q <= rx_byte;
            rxv_q <= 1'b1;
        end else if (rxd_rd) begin
            rxv_q <= 1'b0;
        end
    end

    // ---------------- transmitter ----------------
    mshp_tx_state_t tx_st_q;
    logic [3:0]     tx_tk_q;
    logic [2:0]     tx_n_q;
    logic [7:0]     tx_sh_q;
    logic           tx_par_q;
    logic           tx_line_q;
    logic           tx_done;
    logic           tx_go;
    assign tx_busy = tx_st_q != MSHP_T_IDLE;
    assign tx_go   = wr_acc && avs_address_i == `MSHP_TXD_ADDR
                     && avs_byteenable_i[0] && !tx_busy;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_q   <= MSHP_T_IDLE;
            tx_tk_q   <= '0;
            tx_n_q    <= '0;
            tx_sh_q   <= '0;
            tx_par_q  <= 1'b0;
            tx_line_q <= 1'b1;
            tx_done   <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (tx_go) begin
                tx_sh_q  <= avs_writedata_i[7:0];
                tx_par_q <= par_bit(par_q, avs_writedata_i[7:0]);
                tx_tk_q  <= '0;
                tx_st_q  <= MSHP_T_START;
            end else if (tick && tx_busy) begin
                tx_tk_q <= tx_tk_q + 4'h1;
                case (tx_st_q)
                    MSHP_T_START: begin
                        tx_line_q <= 1'b0;
                        if (tx_tk_q == `MSHP_LAST_TICK) begin
                            tx_n_q  <= '0;
                            tx_st_q <= MSHP_T_DATA;
                        end
                    end
                    MSHP_T_DATA: begin
                        tx_line_q <= tx_sh_q[0];
                        if (tx_tk_q == `MSHP_LAST_TICK) begin
                            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                            tx_n_q  <= tx_n_q + 3'h1;
                            if (tx_n_q == `MSHP_LAST_DBIT) begin
                                tx_st_q <= par_on ? MSHP_T_PAR
                                                  : MSHP_T_STOP;
                            end
                        end
                    end
                    MSHP_T_PAR: begin
                        tx_line_q <= tx_par_q;
                        if (tx_tk_q == `MSHP_LAST_TICK) begin
                            tx_st_q <= MSHP_T_STOP;
                        end
                    end
                    MSHP_T_STOP: begin
                        tx_line_q <= 1'b1;
                        if (tx_tk_q == `MSHP_LAST_TICK) begin
                            tx_st_q <= MSHP_T_IDLE;
                            tx_done <= 1'b1;
                        end
                    end
                    default: tx_st_q <= MSHP_T_IDLE;
                endcase
            end
        end
    end

    // ---------------- status and interrupt ----------------
    assign ev[`MSHP_ST_RXRDY]   = rx_done;
    assign ev[`MSHP_ST_TXDONE]  = tx_done;
    assign ev[`MSHP_ST_OVERRUN] = rx_done && rxv_q && !rxd_rd;
    assign ev[`MSHP_ST_PARERR]  = rx_done && rx_perr;
    assign ev[`MSHP_ST_FRMERR]  = rx_done && rx_ferr;
    assign ev[`MSHP_ST_DEFLT]   = hold_done || deflt_cmd;

    // an event in the clearing cycle survives the clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else if (wr_acc && avs_address_i == `MSHP_STAT_ADDR) begin
            stat_q <= (stat_q & ~wbits[`MSHP_ST_W-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    // ---------------- read data ----------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (avs_read_i && wait_q) begin
            case (avs_address_i)
                `MSHP_CTRL_ADDR: rdata_q <= {28'h0, srq_q, par_q};
                `MSHP_STAT_ADDR: rdata_q <= {26'h0, stat_q};
                `MSHP_MASK_ADDR: rdata_q <= {26'h0, mask_q};
                `MSHP_RXD_ADDR:  rdata_q <= {23'h0, rxv_q, rxd_q};
                `MSHP_CFG_ADDR:  rdata_q <= {19'h0, cfg_q};
                `MSHP_LINK_ADDR: rdata_q <= {29'h0, hold_act_q, rxv_q,
                                             tx_busy};
                default:         rdata_q <= '0;
            endcase
        end
    end

    // ---------------- output flops ----------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o      <= 1'b0;
            host_rxd_o <= 1'b0;
            status_n_o <= 1'b1;
            cts_o      <= 1'b0;
            cts_oe_n_o <= 1'b1;
            cfg_o      <= `MSHP_CFG_DEFAULT;
        end else begin
            irq_o      <= |(stat_q & mask_q);
            host_rxd_o <= ~tx_line_q;
            status_n_o <= ~srq_q;
            cts_o      <= 1'b0;
            cts_oe_n_o <= 1'b1;
            cfg_o      <= cfg_q;
        end
    end

    // rts_i is accepted and deliberately never read
    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
endmodule : mshp_top

//--- tb.sv
// Purpose: self-checking bench for the serial host port
// Assumes: host model on the serial pins, avalon master tasks
// Notes:   two full frames each way dominate the run time
`timescale 1ns/1ps
`include "mshp_regs.svh"
module tb;
    localparam int HOLD  = 50;
    localparam int BITC  = `MSHP_OVS_DIV * `MSHP_OVS;
    localparam int LIMIT = 100000;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  adr   = 8'h00;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        rts   = 1'b0;
    logic        btn   = 1'b1;
    logic [12:0] nv    = 13'h1abc;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [12:0] cfg;
    logic [10:0] fr;
    logic        wreq, irq, rxd, txd, srq_n, cts, cts_oe_n;
    int          mismatches = 0;
    int          checks = 0;
    int          cyc = 0;

    always #12.5 clk = ~clk;

    mshp_top #(.HOLD_CYC(HOLD)) u_dut (
        .core_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .irq_o(irq), .host_txd_i(txd),
        .host_rxd_o(rxd), .status_n_o(srq_n), .rts_i(rts), .cts_o(cts),
        .cts_oe_n_o(cts_oe_n), .panel_btn_i(btn), .nv_cfg_i(nv),
        .cfg_o(cfg)
    );
    mshp_host_model #(.BIT_CYC(BITC)) u_host (
        .clk_i(clk), .line_i(rxd), .line_o(txd)
    );

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        adr <= a;
        wdata <= v;
        wr <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
    endtask : bus_rd

    // both directions at once to keep the run short
    task automatic pair(input logic [7:0] tx, input logic [10:0] hf,
                        input logic [10:0] ef, input int n);
        fork
            bus_wr(`MSHP_TXD_ADDR, {24'h0, tx});
            u_host.send(hf, n);
            u_host.recv(fr, n);
        join
        chk("tx_frame", {21'h0, ef}, {21'h0, fr});
        do bus_rd(`MSHP_LINK_ADDR, d); while (d[0] !== 1'b0);
    endtask : pair

    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("cfg_nv", 32'h1abc, 32'(cfg));
        chk("cts", 32'h2, 32'({cts_oe_n, cts}));
        chk("srq_idle", 32'h1, 32'(srq_n));
        chk("rxd_idle", 32'h0, 32'(rxd));
        rts <= 1'b1;
        repeat (HOLD + 10) @(posedge clk);
        btn <= 1'b0;
        chk("cfg_btn", 32'h1316, 32'(cfg));
        bus_rd(`MSHP_STAT_ADDR, d);
        chk("stat_dflt", 32'h20, d);
        bus_wr(`MSHP_MASK_ADDR, 32'h20);
        repeat (2) @(posedge clk);
        chk("irq_on", 32'h1, 32'(irq));
        bus_wr(`MSHP_STAT_ADDR, 32'h20);
        repeat (2) @(posedge clk);
        chk("irq_clr", 32'h0, 32'(irq));
        bus_rd(8'h1c, d);
        chk("unmapped", 32'h0, d);
        bus_wr(`MSHP_CTRL_ADDR, 32'h8);
        repeat (3) @(posedge clk);
        chk("srq_on", 32'h0, 32'(srq_n));
        chk("cts_rts", 32'h2, 32'({cts_oe_n, cts}));
        bus_wr(`MSHP_CFG_ADDR, 32'h0abc);
        bus_wr(`MSHP_CTRL_ADDR, 32'h10);
        repeat (4) @(posedge clk);
        chk("cfg_cmd", 32'h0316, 32'(cfg));
        chk("srq_off", 32'h1, 32'(srq_n));
        chk("irq_cmd", 32'h1, 32'(irq));
        for (int i = 0; i < 5; i++) begin
            bus_wr(`MSHP_CTRL_ADDR, 32'(i));
            bus_rd(`MSHP_CTRL_ADDR, d);
            chk("par_mode", 32'(i), d & 32'h7);
        end
        bus_wr(`MSHP_CTRL_ADDR, 32'h0);
        bus_wr(`MSHP_STAT_ADDR, 32'h3f);
        bus_wr(`MSHP_MASK_ADDR, 32'h3);
        pair(8'ha5, {2'b11, 8'h3c, 1'b0}, {2'b11, 8'ha5, 1'b0}, 10);
        bus_rd(`MSHP_RXD_ADDR, d);
        chk("rx_byte", 32'h13c, d);
        bus_rd(`MSHP_STAT_ADDR, d);
        chk("stat_8n1", 32'h3, d);
        chk("irq_rx", 32'h1, 32'(irq));
        bus_wr(`MSHP_STAT_ADDR, 32'h3f);
        bus_wr(`MSHP_CTRL_ADDR, 32'h2);
        pair(8'h07, {2'b10, 8'h81, 1'b0}, {2'b11, 8'h07, 1'b0}, 11);
        bus_rd(`MSHP_RXD_ADDR, d);
        chk("rx_par", 32'h181, d);
        bus_rd(`MSHP_STAT_ADDR, d);
        chk("stat_par", 32'h3, d);
        bus_wr(`MSHP_MASK_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        chk("irq_mask", 32'h0, 32'(irq));
        print_verdict();
    end
endmodule : tb
